/* File: ecj_pkg.sv */
// Package for the per-channel receive attenuator and transmit driver configuration bank.
// Assumes one 40 MHz clock and an 11-bit byte-wide register port owned by the device.
package ecj_pkg;

  // Channel count: channel zero plus channels one to twenty-one.
  localparam int ECJ_NCH = 22;
  localparam int ECJ_AW = 11;

  // Register placement inside each channel's 64-byte page.
  localparam logic [5:0] ECJ_RJA_OFS = 6'h03;
  localparam logic [5:0] ECJ_TCF_OFS = 6'h04;
  localparam logic [4:0] ECJ_CH0_PAGE = 5'h1F;
  localparam logic [4:0] ECJ_LAST_PAGE = 5'h14;

  // Reset values of both registers.
  localparam logic [4:0] ECJ_RJA_RST = 5'h00;
  localparam logic [6:0] ECJ_TCF_RST = 7'h00;

  // Receive attenuator field positions.
  localparam int ECJ_RJA_GUARD = 4;
  localparam int ECJ_RX_ATTEN_ENABLE = 3;
  localparam int ECJ_RJA_DP_HI = 2;
  localparam int ECJ_RJA_DP_LO = 1;
  localparam int ECJ_RX_ATTEN_CORNER_SEL = 0;

  // Transmit driver field positions.
  localparam int ECJ_TCF_OE = 6;
  localparam int ECJ_TCF_OFF = 5;
  localparam int ECJ_TCF_OCHZ = 4;
  localparam int ECJ_TCF_SING = 3;
  localparam int ECJ_TCF_TERM_HI = 2;

  // Attenuator FIFO depths and the guard margin in bits.
  localparam logic [7:0] ECJ_DEPTH_128 = 8'h80;
  localparam logic [7:0] ECJ_DEPTH_64 = 8'h40;
  localparam logic [7:0] ECJ_DEPTH_32 = 8'h20;
  localparam logic [7:0] ECJ_GUARD_MARGIN = 8'h02;

  // Over-current escalation time and its cycle count at the clock rate.
  localparam int ECJ_OC_TIME_US = 1000;
  localparam int ECJ_CLK_KHZ = 40000;
  localparam logic [15:0] ECJ_OC_CYCLES = 16'(ECJ_OC_TIME_US * ECJ_CLK_KHZ / 1000);

  // Receive attenuator controls and guard outputs for one channel.
  typedef struct packed {
    logic rx_atten_enable;
    logic [1:0] rx_atten_fifo_depth;
    logic rx_atten_corner_sel;
    logic rx_atten_fifo_guard_en;
    logic guard_speed_up;
    logic guard_slow_down;
  } ecj_rx_ctl_t;

  // Transmit line driver controls for one channel.
  typedef struct packed {
    logic tx_tip_oe;
    logic tx_ring_oe;
    logic tx_power_down;
    logic tx_current_limit;
    logic tx_single_ended_sel;
    logic [2:0] tx_term_sel;
  } ecj_tx_ctl_t;

  // Result of an address decode.
  typedef struct packed {
    logic hit;
    logic is_tx;
    logic [4:0] ch;
  } ecj_dec_t;

  // Whole state of the bank.
  typedef struct packed {
    logic [ECJ_NCH-1:0][4:0] rx_jitter_atten_config;
    logic [ECJ_NCH-1:0][6:0] tcf;
    logic [ECJ_NCH-1:0][15:0] oc_cnt;
    ecj_rx_ctl_t [ECJ_NCH-1:0] rx_ctl;
    ecj_tx_ctl_t [ECJ_NCH-1:0] tx_ctl;
    logic [7:0] rd_data;
  } ecj_state_t;

endpackage : ecj_pkg

/* File: ecj_chan_cfg.sv */
// Per-channel receive jitter attenuator and transmit driver configuration bank.
// Assumes a synchronous register port with one-cycle strobes and reads answered one cycle later.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps

// Function
// - Attenuator register per channel, stride 040H, CH0 7C3H.
// - Driver register per channel, stride 040H, CH0 7C4H.
// - Both registers read/write, reset to zero.
// - Guard adjusts rate within two bits of limits.
// - Attenuator bit 3 enables the attenuator.
// - Depth bits select 128, 64 or 32.
// - Bit 0 selects 6.77 Hz or 0.87 Hz.
// - Driver bit 6 clear holds outputs high-Z.
// - Driver bit 5 powers the transmitter down.
// - Over-current limits; optionally high-Z after 1 ms.
// - Bit 3 selects single-ended tip-only drive.
// - Bits 2 to 0 select impedance matching.
module ecj_chan_cfg
  import ecj_pkg::*;
#(
  parameter logic [15:0] OC_CYCLES = ECJ_OC_CYCLES
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port.
  input wire logic [ECJ_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Attenuator FIFO fill and driver over-current sense, per channel slot.
  input wire logic [ECJ_NCH-1:0][7:0] rx_atten_fifo_level,
  input wire logic [ECJ_NCH-1:0] tx_overcurrent_detect,
  // Controls to the attenuators and line drivers.
  output ecj_rx_ctl_t [ECJ_NCH-1:0] rx_atten_ctl,
  output ecj_tx_ctl_t [ECJ_NCH-1:0] tx_driver_ctl
);

  // Maps a byte address to a channel slot; slot zero is channel zero.
  function automatic ecj_dec_t ecj_decode(input logic [ECJ_AW-1:0] a);
    ecj_dec_t d;
    logic [4:0] page;
    d = '0;
    page = a[10:6];
    d.is_tx = (a[5:0] == ECJ_TCF_OFS);
    if ((a[5:0] == ECJ_RJA_OFS) || d.is_tx) begin
      if (page == ECJ_CH0_PAGE) begin
        d.hit = 1'b1;
        d.ch = 5'h00;
      end else if (page <= ECJ_LAST_PAGE) begin
        d.hit = 1'b1;
        d.ch = page + 5'h01;
      end
    end
    return d;
  endfunction : ecj_decode

  // FIFO depth in bits for a depth code; the upper code bit alone picks 32.
  function automatic logic [7:0] ecj_depth(input logic [1:0] code);
    logic [7:0] dep;
    if (code[1]) begin
      dep = ECJ_DEPTH_32;
    end else if (code[0]) begin
      dep = ECJ_DEPTH_64;
    end else begin
      dep = ECJ_DEPTH_128;
    end
    return dep;
  endfunction : ecj_depth

  ecj_state_t st_ff;
  ecj_state_t nxt_st;
  ecj_dec_t dec;

  // Register access and per-channel control derivation. Controls are built from the updated
  // register image so a write reaches the outputs at the next edge, the same edge as storage.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_data = 8'h00;
    dec = ecj_decode(reg_addr);
    if (reg_wr && dec.hit) begin
      if (dec.is_tx) begin
        nxt_st.tcf[dec.ch] = reg_wdata[6:0];
      end else begin
        nxt_st.rx_jitter_atten_config[dec.ch] = reg_wdata[4:0];
      end
    end
    // Unmapped reads answer zero rather than stale data.
    if (reg_rd && dec.hit) begin
      if (dec.is_tx) begin
        nxt_st.rd_data = {1'b0, st_ff.tcf[dec.ch]};
      end else begin
        nxt_st.rd_data = {3'b000, st_ff.rx_jitter_atten_config[dec.ch]};
      end
    end
    for (int i = 0; i < ECJ_NCH; i++) begin
      // Attenuator controls follow their register bits directly.
      nxt_st.rx_ctl[i].rx_atten_enable = nxt_st.rx_jitter_atten_config[i][ECJ_RX_ATTEN_ENABLE];
      nxt_st.rx_ctl[i].rx_atten_fifo_depth = nxt_st.rx_jitter_atten_config[i][ECJ_RJA_DP_HI:ECJ_RJA_DP_LO];
      nxt_st.rx_ctl[i].rx_atten_corner_sel = nxt_st.rx_jitter_atten_config[i][ECJ_RX_ATTEN_CORNER_SEL];
      nxt_st.rx_ctl[i].rx_atten_fifo_guard_en = nxt_st.rx_jitter_atten_config[i][ECJ_RJA_GUARD];
      // Guard: near full speeds the output up, near empty slows it; inert when the attenuator is off.
      nxt_st.rx_ctl[i].guard_speed_up = nxt_st.rx_jitter_atten_config[i][ECJ_RJA_GUARD] && nxt_st.rx_jitter_atten_config[i][ECJ_RX_ATTEN_ENABLE] &&
        (rx_atten_fifo_level[i] >=
         ecj_depth(nxt_st.rx_jitter_atten_config[i][ECJ_RJA_DP_HI:ECJ_RJA_DP_LO]) - ECJ_GUARD_MARGIN);
      nxt_st.rx_ctl[i].guard_slow_down = nxt_st.rx_jitter_atten_config[i][ECJ_RJA_GUARD] && nxt_st.rx_jitter_atten_config[i][ECJ_RX_ATTEN_ENABLE] &&
        (rx_atten_fifo_level[i] <= ECJ_GUARD_MARGIN);
      // Over-current persistence counter; it saturates so a long fault cannot wrap back to limiting.
      if (!tx_overcurrent_detect[i]) begin
        nxt_st.oc_cnt[i] = 16'h0000;
      end else if (st_ff.oc_cnt[i] < OC_CYCLES) begin
        nxt_st.oc_cnt[i] = st_ff.oc_cnt[i] + 16'h0001;
      end
      // Driver enables: high-Z when output disabled, powered down, or escalated over-current.
      nxt_st.tx_ctl[i].tx_tip_oe = nxt_st.tcf[i][ECJ_TCF_OE] && !nxt_st.tcf[i][ECJ_TCF_OFF] &&
        !(nxt_st.tcf[i][ECJ_TCF_OCHZ] && (nxt_st.oc_cnt[i] >= OC_CYCLES));
      // Single-ended mode leaves the ring output open.
      nxt_st.tx_ctl[i].tx_ring_oe = nxt_st.tx_ctl[i].tx_tip_oe && !nxt_st.tcf[i][ECJ_TCF_SING];
      nxt_st.tx_ctl[i].tx_power_down = nxt_st.tcf[i][ECJ_TCF_OFF];
      nxt_st.tx_ctl[i].tx_current_limit = tx_overcurrent_detect[i];
      nxt_st.tx_ctl[i].tx_single_ended_sel = nxt_st.tcf[i][ECJ_TCF_SING];
      // Reserved matching codes are passed on unchanged; the analog side treats them as undefined.
      nxt_st.tx_ctl[i].tx_term_sel = nxt_st.tcf[i][ECJ_TCF_TERM_HI:0];
    end
  end

  // State register; the clock enable freezes everything, including the escalation timer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata = st_ff.rd_data;
  assign rx_atten_ctl = st_ff.rx_ctl;
  assign tx_driver_ctl = st_ff.tx_ctl;

  // Checks run on enabled edges, except the freeze check on every edge; slot one is watched in detail as a representative channel.
  localparam int AC = 1;
  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (!rst_b);

  // A write to slot one's attenuator register lands in storage and controls at the next edge.
  sequence s_rja_wr;
    reg_wr && (reg_addr == {5'h00, ECJ_RJA_OFS});
  endsequence
  a_rja_write_lands: assert property (s_rja_wr |=> (st_ff.rx_jitter_atten_config[AC] == $past(reg_wdata[4:0])) &&
    (rx_atten_ctl[AC].rx_atten_enable == $past(reg_wdata[ECJ_RX_ATTEN_ENABLE])))
    else $error("Attenuator write did not reach slot one.");

  // A write to channel zero's driver register lands at slot zero.
  a_ch0_tcf_write: assert property (reg_wr && (reg_addr == {ECJ_CH0_PAGE, ECJ_TCF_OFS}) |=>
    st_ff.tcf[0] == $past(reg_wdata[6:0]))
    else $error("Channel zero driver write was lost.");

  // A read answers the stored value one cycle later with reserved bits clear.
  sequence s_tcf_rd;
    reg_rd && (reg_addr == {5'h00, ECJ_TCF_OFS});
  endsequence
  a_tcf_read_back: assert property (s_tcf_rd |=> reg_rdata == {1'b0, $past(st_ff.tcf[AC])})
    else $error("Driver register read back wrong.");

  // Reserved attenuator bits never read as one.
  a_rja_rsvd_zero: assert property (reg_rd && (reg_addr[5:0] == ECJ_RJA_OFS) |=> reg_rdata[7:5] == 3'b000)
    else $error("Reserved attenuator bits read as one.");

  // With output enable clear the tip stays off.
  a_oe_clear_hiz: assert property (!st_ff.tcf[AC][ECJ_TCF_OE] |-> !tx_driver_ctl[AC].tx_tip_oe &&
    !tx_driver_ctl[AC].tx_ring_oe)
    else $error("Driver enabled while output enable clear.");

  // Power-down forces the tip output off.
  a_power_down_off: assert property (tx_driver_ctl[AC].tx_power_down |-> !tx_driver_ctl[AC].tx_tip_oe)
    else $error("Driver active while powered down.");

  // Single-ended mode keeps the ring open while the tip may drive.
  a_single_ring_off: assert property (tx_driver_ctl[AC].tx_single_ended_sel |-> !tx_driver_ctl[AC].tx_ring_oe)
    else $error("Ring driven in single-ended mode.");

  // Without escalation a sustained fault never tristates an enabled driver.
  a_oc_limit_only: assert property (!st_ff.tcf[AC][ECJ_TCF_OCHZ] && st_ff.tcf[AC][ECJ_TCF_OE] &&
    !st_ff.tcf[AC][ECJ_TCF_OFF] |-> tx_driver_ctl[AC].tx_tip_oe)
    else $error("Driver tristated without escalation selected.");

  // With escalation, a fault held past the limit turns the tip off.
  a_oc_escalate: assert property (st_ff.tcf[AC][ECJ_TCF_OCHZ] && (st_ff.oc_cnt[AC] >= OC_CYCLES) |->
    !tx_driver_ctl[AC].tx_tip_oe)
    else $error("Over-current did not escalate to high-Z.");

  // The counter restarts as soon as the fault clears.
  a_oc_restart: assert property (!tx_overcurrent_detect[AC] |=> st_ff.oc_cnt[AC] == 16'h0000)
    else $error("Over-current timer did not restart.");

  // Guard outputs stay quiet while the guard is disabled.
  a_guard_quiet: assert property (!rx_atten_ctl[AC].rx_atten_fifo_guard_en |->
    !rx_atten_ctl[AC].guard_speed_up && !rx_atten_ctl[AC].guard_slow_down)
    else $error("Guard acted while disabled.");

  // Depth and corner follow their stored bits.
  a_depth_corner: assert property (rx_atten_ctl[AC].rx_atten_fifo_depth == st_ff.rx_jitter_atten_config[AC][2:1] &&
    rx_atten_ctl[AC].rx_atten_corner_sel == st_ff.rx_jitter_atten_config[AC][0])
    else $error("Depth or corner control disagrees with register.");

  // Matching selection follows the stored code.
  a_term_follow: assert property (tx_driver_ctl[AC].tx_term_sel == st_ff.tcf[AC][2:0])
    else $error("Matching selection disagrees with register.");

  // Slot one's attenuator register read answers its stored value with reserved bits clear.
  sequence s_rja_rd;
    reg_rd && (reg_addr == {5'h00, ECJ_RJA_OFS});
  endsequence
  a_rja_read_back: assert property (s_rja_rd |=> reg_rdata == {3'b000, $past(st_ff.rx_jitter_atten_config[AC])})
    else $error("Attenuator register read back wrong.");

  // Read data stands for one cycle only, so an idle cycle must answer zero.
  a_rd_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data present without a read.");

  // Offsets that hold neither register answer zero.
  a_unmapped_ofs: assert property (reg_rd && (reg_addr[5:0] != ECJ_RJA_OFS) && (reg_addr[5:0] != ECJ_TCF_OFS) |=>
    reg_rdata == 8'h00)
    else $error("Unmapped offset answered data.");

  // Pages beyond the last channel, other than channel zero's page, answer zero.
  a_unmapped_page: assert property (reg_rd && (reg_addr[10:6] > ECJ_LAST_PAGE) &&
    (reg_addr[10:6] != ECJ_CH0_PAGE) |=> reg_rdata == 8'h00)
    else $error("Unmapped page answered data.");

  // A write to channel zero's attenuator register lands at slot zero.
  a_ch0_rja_write: assert property (reg_wr && (reg_addr == {ECJ_CH0_PAGE, ECJ_RJA_OFS}) |=>
    st_ff.rx_jitter_atten_config[0] == $past(reg_wdata[4:0]))
    else $error("Channel zero attenuator write was lost.");

  // A write to slot one's driver register lands with the reserved bit dropped.
  sequence s_tcf_wr;
    reg_wr && (reg_addr == {5'h00, ECJ_TCF_OFS});
  endsequence
  a_tcf_write_lands: assert property (s_tcf_wr |=> st_ff.tcf[AC] == $past(reg_wdata[6:0]))
    else $error("Driver write did not reach slot one.");

  // The reserved driver bit never reads as one.
  a_tcf_rsvd_zero: assert property (reg_rd && (reg_addr[5:0] == ECJ_TCF_OFS) |=> !reg_rdata[7])
    else $error("Reserved driver bit read as one.");

  // Attenuator enable follows its stored bit.
  a_enable_follow: assert property (rx_atten_ctl[AC].rx_atten_enable == st_ff.rx_jitter_atten_config[AC][ECJ_RX_ATTEN_ENABLE])
    else $error("Attenuator enable disagrees with register.");

  // Guard enable follows its stored bit.
  a_guard_en_follow: assert property (rx_atten_ctl[AC].rx_atten_fifo_guard_en == st_ff.rx_jitter_atten_config[AC][ECJ_RJA_GUARD])
    else $error("Guard enable disagrees with register.");

  // A disabled attenuator never receives rate corrections.
  a_atten_off_quiet: assert property (!rx_atten_ctl[AC].rx_atten_enable |->
    !rx_atten_ctl[AC].guard_speed_up && !rx_atten_ctl[AC].guard_slow_down)
    else $error("Guard acted while attenuator disabled.");

  // Guard armed: both its own enable and the attenuator enable are stored as one.
  sequence s_guard_armed;
    st_ff.rx_jitter_atten_config[AC][ECJ_RJA_GUARD] && st_ff.rx_jitter_atten_config[AC][ECJ_RX_ATTEN_ENABLE];
  endsequence
  a_guard_slow_hit: assert property (s_guard_armed ##0 ($past(rx_atten_fifo_level[AC]) <= ECJ_GUARD_MARGIN) |->
    rx_atten_ctl[AC].guard_slow_down)
    else $error("Guard missed a near-empty FIFO.");

  // Near full at the deepest setting must speed the output up.
  a_guard_full_128: assert property (s_guard_armed ##0 (st_ff.rx_jitter_atten_config[AC][2:1] == 2'b00) ##0
    ($past(rx_atten_fifo_level[AC]) >= ECJ_DEPTH_128 - ECJ_GUARD_MARGIN) |-> rx_atten_ctl[AC].guard_speed_up)
    else $error("Guard missed a near-full deep FIFO.");

  // Near full at the shallowest setting must speed the output up.
  a_guard_full_32: assert property (s_guard_armed ##0 st_ff.rx_jitter_atten_config[AC][2] ##0
    ($past(rx_atten_fifo_level[AC]) >= ECJ_DEPTH_32 - ECJ_GUARD_MARGIN) |-> rx_atten_ctl[AC].guard_speed_up)
    else $error("Guard missed a near-full shallow FIFO.");

  // Slowing down is only ever asked for near empty.
  a_guard_slow_level: assert property (rx_atten_ctl[AC].guard_slow_down |->
    $past(rx_atten_fifo_level[AC]) <= ECJ_GUARD_MARGIN)
    else $error("Guard slowed down away from empty.");

  // Speeding up is never asked for below the shallowest near-full level.
  a_guard_fast_level: assert property (rx_atten_ctl[AC].guard_speed_up |->
    $past(rx_atten_fifo_level[AC]) >= ECJ_DEPTH_32 - ECJ_GUARD_MARGIN)
    else $error("Guard sped up away from full.");

  // A comfortably filled FIFO needs no correction.
  a_guard_mid_quiet: assert property (($past(rx_atten_fifo_level[AC]) > ECJ_GUARD_MARGIN) &&
    ($past(rx_atten_fifo_level[AC]) < ECJ_DEPTH_32 - ECJ_GUARD_MARGIN) |->
    !rx_atten_ctl[AC].guard_speed_up && !rx_atten_ctl[AC].guard_slow_down)
    else $error("Guard acted at a middle fill level.");

  // The ring never drives without the tip.
  a_ring_needs_tip: assert property (tx_driver_ctl[AC].tx_ring_oe |-> tx_driver_ctl[AC].tx_tip_oe)
    else $error("Ring driven without the tip.");

  // Differential drive uses both outputs.
  a_diff_ring_on: assert property (tx_driver_ctl[AC].tx_tip_oe && !tx_driver_ctl[AC].tx_single_ended_sel |->
    tx_driver_ctl[AC].tx_ring_oe)
    else $error("Ring open in differential mode.");

  // Power-down also leaves the ring open.
  a_power_ring_off: assert property (tx_driver_ctl[AC].tx_power_down |-> !tx_driver_ctl[AC].tx_ring_oe)
    else $error("Ring driven while powered down.");

  // Power-down control follows its stored bit.
  a_power_follow: assert property (tx_driver_ctl[AC].tx_power_down == st_ff.tcf[AC][ECJ_TCF_OFF])
    else $error("Power-down control disagrees with register.");

  // Single-ended selection follows its stored bit.
  a_single_follow: assert property (tx_driver_ctl[AC].tx_single_ended_sel == st_ff.tcf[AC][ECJ_TCF_SING])
    else $error("Single-ended control disagrees with register.");

  // Current limiting tracks the sensed fault one edge later.
  a_limit_mirror: assert property (tx_driver_ctl[AC].tx_current_limit == $past(tx_overcurrent_detect[AC]))
    else $error("Current limit does not track the fault.");

  // A fault held below the limit advances the timer by one per enabled edge.
  sequence s_fault_held;
    tx_overcurrent_detect[AC] && (st_ff.oc_cnt[AC] < OC_CYCLES);
  endsequence
  a_oc_count_up: assert property (s_fault_held |=> st_ff.oc_cnt[AC] == $past(st_ff.oc_cnt[AC]) + 16'h0001)
    else $error("Over-current timer did not advance.");

  // The timer saturates at the limit.
  a_oc_saturate: assert property (st_ff.oc_cnt[AC] <= OC_CYCLES)
    else $error("Over-current timer ran past its limit.");

  // Within the first stretch of a fault an enabled driver stays on the line.
  a_oc_early_on: assert property (st_ff.tcf[AC][ECJ_TCF_OE] && !st_ff.tcf[AC][ECJ_TCF_OFF] &&
    (st_ff.oc_cnt[AC] < OC_CYCLES) |-> tx_driver_ctl[AC].tx_tip_oe)
    else $error("Driver dropped before the fault persisted.");

  // Channel zero also stays high-Z while its output enable is clear.
  a_ch0_oe_hiz: assert property (!st_ff.tcf[0][ECJ_TCF_OE] |-> !tx_driver_ctl[0].tx_tip_oe &&
    !tx_driver_ctl[0].tx_ring_oe)
    else $error("Channel zero driver enabled while output enable clear.");

  // A low clock enable freezes the whole state; this check needs every edge, not just enabled ones.
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_b) !ce |=> st_ff == $past(st_ff))
    else $error("State changed while the clock enable was low.");

endmodule : ecj_chan_cfg

/* File: ecj_chan_cfg_tb.sv */
// Self-checking bench for the per-channel attenuator and line driver configuration bank.
// Assumes the bank alone on a 40 MHz clock; this bench drives the register port and sense inputs.
`timescale 1ns/1ps
module tb;
  import ecj_pkg::*;
  // The escalation count is shortened so the over-current case runs in a few dozen cycles.
  localparam logic [15:0] OC = 16'h0010;
  logic clk, rst_b, ce, reg_wr, reg_rd;
  logic [10:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [ECJ_NCH-1:0][7:0] lvl;
  logic [ECJ_NCH-1:0] ocd;
  ecj_rx_ctl_t [ECJ_NCH-1:0] rxc;
  ecj_tx_ctl_t [ECJ_NCH-1:0] txc;
  int fails, check_count;

  ecj_chan_cfg #(.OC_CYCLES(OC)) dut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_atten_fifo_level(lvl), .tx_overcurrent_detect(ocd), .rx_atten_ctl(rxc), .tx_driver_ctl(txc));

  // Free-running clock, 25 ns period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // One byte compare; every check goes through here so the counts stay honest.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Byte address of a channel's register; channel zero lives on the top page.
  function automatic logic [10:0] adr(input int ch, input logic [10:0] ofs);
    adr = (ch == 0) ? (11'h7c0 | ofs) : ofs + 11'h040 * 11'(ch - 1);
  endfunction : adr

  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is taken in the cycle after the strobe edge, where it stands.
  task automatic rd(input logic [10:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Lets registered outputs settle past the edge before sampling.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_map;
    for (int ch = 0; ch < ECJ_NCH; ch++) begin
      rd(adr(ch, 11'h003), d);
      chk(d, 8'h00);
      wr(adr(ch, 11'h003), 8'he0 | 8'(ch));
      wr(adr(ch, 11'h004), 8'hc0 | 8'(ch));
    end
    // Writes with the clock enable low and to foreign addresses must leave the bank alone.
    @(posedge clk);
    ce <= 1'b0;
    wr(adr(1, 11'h003), 8'h00);
    ce <= 1'b1;
    wr(11'h543, 8'h1f);
    wr(11'h005, 8'hff);
    for (int ch = 0; ch < ECJ_NCH; ch++) begin
      rd(adr(ch, 11'h003), d);
      chk(d, 8'(ch));
      rd(adr(ch, 11'h004), d);
      chk(d, 8'h40 | 8'(ch));
    end
    rd(11'h543, d);
    chk(d, 8'h00);
    settle(1);
    chk(reg_rdata, 8'h00);
    $display("t_map done");
  endtask : t_map

  task automatic t_rx_fields;
    for (int v = 0; v < 32; v++) begin
      wr(adr(1, 11'h003), 8'(v));
      settle(1);
      chk(8'({rxc[1].rx_atten_enable, rxc[1].rx_atten_fifo_depth, rxc[1].rx_atten_corner_sel,
        rxc[1].rx_atten_fifo_guard_en}), 8'({v[3], v[2:1], v[0], v[4]}));
    end
    $display("t_rx_fields done");
  endtask : t_rx_fields

  task automatic guard(input logic [7:0] level, input logic [7:0] exp);
    @(posedge clk);
    lvl[1] <= level;
    settle(3);
    chk(8'({rxc[1].guard_speed_up, rxc[1].guard_slow_down}), exp);
  endtask : guard

  task automatic t_guard;
    logic [7:0] depth;
    for (int c = 0; c < 4; c++) begin
      depth = (c == 0) ? 8'h80 : (c == 1) ? 8'h40 : 8'h20;
      wr(adr(1, 11'h003), 8'h18 | 8'(c << 1));
      guard(depth - 8'h02, 8'h02);
      guard(depth - 8'h03, 8'h00);
      guard(8'h02, 8'h01);
      guard(8'h03, 8'h00);
    end
    // The guard stays quiet when its own enable or the attenuator enable is off.
    wr(adr(1, 11'h003), 8'h08);
    guard(8'h02, 8'h00);
    wr(adr(1, 11'h003), 8'h10);
    guard(8'h02, 8'h00);
    $display("t_guard done");
  endtask : t_guard

  task automatic t_tx_fields;
    logic tip;
    for (int v = 0; v < 128; v++) begin
      wr(adr(2, 11'h004), 8'(v));
      settle(1);
      tip = v[6] & ~v[5];
      chk(8'({txc[2].tx_tip_oe, txc[2].tx_ring_oe, txc[2].tx_power_down, txc[2].tx_single_ended_sel,
        txc[2].tx_term_sel}), 8'({tip, tip & ~v[3], v[5], v[3], v[2:0]}));
    end
    $display("t_tx_fields done");
  endtask : t_tx_fields

  task automatic t_overcurrent;
    // Slot one is the slot the in-design checks watch, so the escalation path is exercised there.
    wr(adr(1, 11'h004), 8'h50);
    ocd[1] <= 1'b1;
    settle(32'(OC) - 2);
    chk(8'({txc[1].tx_tip_oe, txc[1].tx_ring_oe, txc[1].tx_current_limit}), 8'h07);
    settle(4);
    chk(8'({txc[1].tx_tip_oe, txc[1].tx_ring_oe, txc[1].tx_current_limit}), 8'h01);
    ocd[1] <= 1'b0;
    settle(3);
    chk(8'({txc[1].tx_tip_oe, txc[1].tx_ring_oe, txc[1].tx_current_limit}), 8'h06);
    // Without the escalation bit the driver keeps limiting and stays on the line.
    wr(adr(1, 11'h004), 8'h40);
    ocd[1] <= 1'b1;
    settle(32'(OC) + 8);
    chk(8'({txc[1].tx_tip_oe, txc[1].tx_ring_oe, txc[1].tx_current_limit}), 8'h07);
    ocd[1] <= 1'b0;
    $display("t_overcurrent done");
  endtask : t_overcurrent

  task automatic final_report;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Watchdog so a stuck run still ends with a verdict.
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end

  // Main sequence: reset for 20 cycles, then the scenarios in turn.
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 11'h000;
    reg_wdata = 8'h00;
    lvl = '0;
    ocd = '0;
    fails = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    settle(1);
    chk(8'({txc[0].tx_tip_oe, txc[0].tx_ring_oe}), 8'h00);
    t_map();
    t_rx_fields();
    t_guard();
    t_tx_fields();
    t_overcurrent();
    final_report();
  end
endmodule : tb
